// >>> hdl/qec_consts.vh
// Constants for the quadrature encoder counter: offsets, fields, resets, timing
`ifndef QEC_CONSTS_VH
`define QEC_CONSTS_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define QEC_OFS_CTRL    12'h000
`define QEC_OFS_STATUS  12'h004
`define QEC_OFS_COUNT   12'h008
`define QEC_OFS_RAW     12'h00c

// ----------------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------------
`define QEC_CTRL_ARM        0
`define QEC_CTRL_CLEAR      1
`define QEC_CTRL_SINGLE     2
`define QEC_CTRL_FILTER     3
`define QEC_CTRL_IDX_RISE   4
`define QEC_CTRL_GATE_EN    5
`define QEC_CTRL_GATE_LOW   6
`define QEC_CTRL_W          7
`define QEC_CTRL_RESET      7'h08

// ----------------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------------
`define QEC_STAT_ARM        0
`define QEC_STAT_A          1
`define QEC_STAT_B          2
`define QEC_STAT_IDX        3
`define QEC_STAT_GATE       4

// ----------------------------------------------------------------------------
// Filter timing in sample clocks
// ----------------------------------------------------------------------------
`define QEC_FILT_LONG   4'd15
`define QEC_FILT_SHORT  4'd3

`endif

// >>> hdl/qec_counter.v
// Quadrature encoder counter with glitch filter, index clear and APB registers
`timescale 1ns/1ps
`include "qec_consts.vh"

// Functional notes
// - Keep a signed 32-bit count of edges since that count was last cleared.
// - While armed, the next qualified index clears the count and the arm bit together.
// - Keep a second signed total of all edges, untouched by index or clear.
// - While clear is set the count is held at zero.
// - Single-phase bit low selects quadrature, high selects A-step B-direction.
// - Filter on needs 15 stable clocks to accept a change, off needs 3.
// - The same filter applies to phase A, phase B and index.
// - Index polarity bit high triggers on rising index, low on falling, only while armed.
// - With gating enabled an index counts only while the gate is qualifying.
// - Gate polarity high needs gate low, low needs gate high.
// - Quadrature counts every edge where only one phase moves, four per line.
// - Single-phase counts on each rising A edge, direction from B.
// - A build parameter selects three or four inputs per channel.
module qec_counter #(
    parameter HAS_GATE = 1
) (
    input  wire        i_clock,
    input  wire        i_rst,
    input  wire        i_phase_a,
    input  wire        i_phase_b,
    input  wire        i_index,
    input  wire        i_index_gate,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    input  wire [3:0]  pstrb,
    output wire        pready,
    output wire        pslverr,
    output reg  [31:0] prdata
);

// ----------------------------------------------------------------------------
// Registers and state
// ----------------------------------------------------------------------------
reg  [`QEC_CTRL_W-1:0] ctrl_ff;
reg  [2:0]             filt_ff;
reg  [3:0]             cnt_a_ff;
reg  [3:0]             cnt_b_ff;
reg  [3:0]             cnt_i_ff;
reg  [2:0]             prev_ff;
reg  signed [31:0]     count_ff;
reg  signed [31:0]     raw_ff;
reg  [31:0]            nxt_rdata;

wire       wr_en   = psel & penable & pwrite;
wire       rd_en   = psel & ~penable & ~pwrite;
wire [3:0] need    = ctrl_ff[`QEC_CTRL_FILTER] ? `QEC_FILT_LONG : `QEC_FILT_SHORT;
wire       gate_in = (HAS_GATE != 0) ? i_index_gate : 1'b0;

assign pready  = 1'b1;
assign pslverr = 1'b0;

// Counter of stable mismatching samples; accepts once it reaches the need
function [3:0] filt_step;
    input       raw;
    input       cur;
    input [3:0] cnt;
    input [3:0] lim;
    begin
        if (raw == cur)
            filt_step = 4'd0;
        else if (cnt >= lim - 4'd1)
            filt_step = 4'd0;
        else
            filt_step = cnt + 4'd1;
    end
endfunction

function accept;
    input       raw;
    input       cur;
    input [3:0] cnt;
    input [3:0] lim;
    begin
        accept = (raw != cur) && (cnt >= lim - 4'd1);
    end
endfunction

// ----------------------------------------------------------------------------
// Glitch filter, shared form for all three inputs
// ----------------------------------------------------------------------------
always @(posedge i_clock) begin
    if (i_rst) begin
        filt_ff  <= 3'h0;
        cnt_a_ff <= 4'h0;
        cnt_b_ff <= 4'h0;
        cnt_i_ff <= 4'h0;
    end else begin
        cnt_a_ff <= filt_step(i_phase_a, filt_ff[0], cnt_a_ff, need);
        cnt_b_ff <= filt_step(i_phase_b, filt_ff[1], cnt_b_ff, need);
        cnt_i_ff <= filt_step(i_index, filt_ff[2], cnt_i_ff, need);
        if (accept(i_phase_a, filt_ff[0], cnt_a_ff, need))
            filt_ff[0] <= i_phase_a;
        if (accept(i_phase_b, filt_ff[1], cnt_b_ff, need))
            filt_ff[1] <= i_phase_b;
        if (accept(i_index, filt_ff[2], cnt_i_ff, need))
            filt_ff[2] <= i_index;
    end
end

// ----------------------------------------------------------------------------
// Decoder
// ----------------------------------------------------------------------------
reg  step_up;
reg  step_dn;
wire a_now  = filt_ff[0];
wire b_now  = filt_ff[1];
wire a_old  = prev_ff[0];
wire b_old  = prev_ff[1];

always @* begin
    step_up = 1'b0;
    step_dn = 1'b0;
    if (ctrl_ff[`QEC_CTRL_SINGLE]) begin
        if (a_now & ~a_old) begin
            step_up = ~b_now;
            step_dn = b_now;
        end
    end else begin
        // Gray step: exactly one phase moved; both moving is illegal
        if ((a_now ^ a_old) & ~(b_now ^ b_old)) begin
            step_up = a_now ^ b_now;
            step_dn = ~(a_now ^ b_now);
        end else if ((b_now ^ b_old) & ~(a_now ^ a_old)) begin
            step_up = ~(a_now ^ b_now);
            step_dn = a_now ^ b_now;
        end
    end
end

// ----------------------------------------------------------------------------
// Index qualification
// ----------------------------------------------------------------------------
wire idx_edge = ctrl_ff[`QEC_CTRL_IDX_RISE] ? (filt_ff[2] & ~prev_ff[2])
                                              : (~filt_ff[2] & prev_ff[2]);
wire gate_ok  = ctrl_ff[`QEC_CTRL_GATE_LOW] ? ~gate_in : gate_in;
wire idx_hit  = ctrl_ff[`QEC_CTRL_ARM] & idx_edge &
                (~ctrl_ff[`QEC_CTRL_GATE_EN] | gate_ok);

// ----------------------------------------------------------------------------
// Counts and control register
// ----------------------------------------------------------------------------
always @(posedge i_clock) begin
    if (i_rst) begin
        prev_ff  <= 3'h0;
        count_ff <= 32'sh0;
        raw_ff   <= 32'sh0;
        ctrl_ff  <= `QEC_CTRL_RESET;
    end else begin
        prev_ff <= filt_ff;
        if (step_up)
            raw_ff <= raw_ff + 32'sh1;
        else if (step_dn)
            raw_ff <= raw_ff - 32'sh1;
        if (ctrl_ff[`QEC_CTRL_CLEAR] || idx_hit)
            count_ff <= 32'sh0;
        else if (step_up)
            count_ff <= count_ff + 32'sh1;
        else if (step_dn)
            count_ff <= count_ff - 32'sh1;
        if (wr_en && paddr == `QEC_OFS_CTRL && pstrb[0])
            ctrl_ff <= pwdata[`QEC_CTRL_W-1:0];
        // Index clears arm after the write so a hit in the same cycle wins
        if (idx_hit)
            ctrl_ff[`QEC_CTRL_ARM] <= 1'b0;
    end
end

// ----------------------------------------------------------------------------
// APB read data, registered in setup so it is ready in the access phase
// ----------------------------------------------------------------------------
always @* begin
    nxt_rdata = 32'h0;
    case (paddr)
        `QEC_OFS_CTRL:   nxt_rdata = {25'h0, ctrl_ff};
        `QEC_OFS_STATUS: nxt_rdata = {27'h0, gate_in, filt_ff[2], filt_ff[1],
                                      filt_ff[0], ctrl_ff[`QEC_CTRL_ARM]};
        `QEC_OFS_COUNT:  nxt_rdata = count_ff;
        `QEC_OFS_RAW:    nxt_rdata = raw_ff;
        default:         nxt_rdata = 32'h0;
    endcase
end

always @(posedge i_clock) begin
    if (i_rst)
        prdata <= 32'h0;
    else if (rd_en)
        prdata <= nxt_rdata;
end

endmodule // qec_counter

// >>> dv/qec_counter_properties.sv
// Assertions on the encoder counter register port
`timescale 1ns/1ps
module qec_counter_properties #(parameter HAS_GATE = 1) (
    input wire        i_clock,
    input wire        i_rst,
    input wire        i_phase_a,
    input wire        i_phase_b,
    input wire        i_index,
    input wire        i_index_gate,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [3:0]  pstrb,
    input wire        pready,
    input wire        pslverr,
    input wire [31:0] prdata
);
    reg  [6:0] ctrl_ff;
    reg  [4:0] stab_ff;
    reg  [3:0] pins_ff;
    wire [3:0] pins = {i_index_gate, i_index, i_phase_b, i_phase_a};
    wire       rd   = psel && !penable && !pwrite;
    // Stability count lets pin checks wait out the filter
    always @(posedge i_clock) begin
        pins_ff <= pins;
        stab_ff <= (i_rst || pins_ff != pins) ? 5'h00 : stab_ff + {4'h0, stab_ff != 5'h1f};
        if (i_rst) ctrl_ff <= 7'h08;
        else if (psel && penable && pwrite && paddr == 12'h000 && pstrb[0]) ctrl_ff <= pwdata[6:0];
    end
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_rst);
    chk_ready_high: assert property (pready) else $error("ready low");
    chk_no_error: assert property (!pslverr) else $error("error response");
    chk_rdata_hold: assert property (!rd |=> $stable(prdata)) else $error("read data moved");
    chk_unmapped_zero: assert property (rd && paddr > 12'h00c |=> prdata == 32'h0)
        else $error("unmapped read nonzero");
    chk_ctrl_readback: assert property (rd && paddr == 12'h000 |=> prdata[6:1] == ctrl_ff[6:1])
        else $error("control readback");
    chk_arm_only_clears: assert property (rd && paddr == 12'h004 && !ctrl_ff[0] |=> !prdata[0])
        else $error("arm set by hardware");
    chk_clear_holds: assert property (rd && paddr == 12'h008 && ctrl_ff[1] && $past(ctrl_ff[1], 3)
        |=> prdata == 32'h0) else $error("count not held");
    chk_pins_filtered: assert property (rd && paddr == 12'h004 && stab_ff >= 5'd24
        |=> prdata[4:1] == pins_ff) else $error("filtered pins");
endmodule // qec_counter_properties
bind qec_counter qec_counter_properties #(.HAS_GATE(HAS_GATE)) qec_counter_properties_inst (.*);

// >>> dv/qec_enc_model.sv
// Incremental encoder model: gray-coded phases and index
`timescale 1ns/1ps
module qec_enc_model (
    input  wire i_clock,
    output reg  o_phase_a,
    output reg  o_phase_b,
    output reg  o_index
);
    reg [1:0] pos_ff = 2'h0;
    initial {o_index, o_phase_b, o_phase_a} = 3'h0;
    task drive(input [2:0] v, input integer n);
        begin
            // Keep the gray position in step with raw phase drives
            pos_ff = {v[1], v[1] ^ v[0]};
            @(posedge i_clock);
            {o_index, o_phase_b, o_phase_a} <= v;
            repeat (n) @(posedge i_clock);
        end
    endtask
    // Forward is A rising while B low
    task step(input up, input integer n);
        begin
            pos_ff = up ? pos_ff + 2'h1 : pos_ff - 2'h1;
            drive({1'b0, pos_ff[1], pos_ff[1] ^ pos_ff[0]}, n);
        end
    endtask
endmodule // qec_enc_model

// >>> dv/qec_counter_tb_top.sv
// Self-checking bench for the encoder counter
`timescale 1ns/1ps
module qec_counter_tb_top;
    `define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
        $display("wrong value at %0t: got %h want %h", $time, g, e); end end
    reg         i_clock = 0, i_rst = 1, i_index_gate = 0, psel = 0, penable = 0, pwrite = 0;
    reg  [11:0] paddr = 0;
    reg  [31:0] pwdata = 0, rd;
    wire        a, b, idx, pready, pslverr;
    wire [31:0] prdata;
    integer     err_count = 0, samples_checked = 0, cycles = 0, i;
    qec_enc_model enc (.i_clock(i_clock), .o_phase_a(a), .o_phase_b(b), .o_index(idx));
    qec_counter #(.HAS_GATE(1)) qec_counter_inst (.i_clock(i_clock), .i_rst(i_rst),
        .i_phase_a(a), .i_phase_b(b), .i_index(idx), .i_index_gate(i_index_gate),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(4'hf), .pready(pready), .pslverr(pslverr), .prdata(prdata));
    always #2.5 i_clock = ~i_clock;
    task finish_test;
        begin
            $display("errors %0d of %0d checks", err_count, samples_checked);
            if (err_count == 0 && samples_checked > 0) $display("verification passed");
            else $display("verification failed");
            $finish;
        end
    endtask
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 20000) begin err_count++; finish_test(); end
    end
    task apb(input w, input [11:0] ad, input [31:0] d);
        begin
            psel <= 1;
            pwrite <= w;
            paddr <= ad;
            pwdata <= d;
            @(posedge i_clock);
            penable <= 1;
            @(posedge i_clock);
            while (pready !== 1'b1) @(posedge i_clock);
            rd = prdata;
            psel <= 0;
            penable <= 0;
            @(posedge i_clock);
        end
    endtask
    task rchk(input [11:0] ad, input [31:0] e);
        begin apb(0, ad, 0); `CHK(rd, e) end
    endtask
    initial begin
        repeat (4) @(posedge i_clock);
        i_rst <= 0;
        rchk(12'h000, 32'h08);
        rchk(12'h010, 32'h0);
        for (i = 0; i < 5; i++) enc.step(1, 24);
        enc.step(0, 24);
        rchk(12'h008, 32'h4);
        enc.drive(3'h4, 8);
        enc.drive(3'h0, 24);
        rchk(12'h008, 32'h4);
        apb(1, 12'h000, 32'h00);
        for (i = 0; i < 4; i++) enc.step(1, 5);
        rchk(12'h008, 32'h8);
        apb(1, 12'h000, 32'h0a);
        enc.step(1, 24);
        enc.step(1, 24);
        rchk(12'h008, 32'h0);
        rchk(12'h00c, 32'ha);
        apb(1, 12'h000, 32'h0c);
        for (i = 0; i < 3; i++) begin enc.drive(3'h1, 24); enc.drive(3'h0, 24); end
        enc.drive(3'h2, 24);
        enc.drive(3'h3, 24);
        enc.drive(3'h0, 24);
        rchk(12'h008, 32'h1);
        apb(1, 12'h000, 32'h19);
        enc.drive(3'h4, 24);
        enc.drive(3'h0, 24);
        rchk(12'h008, 32'h0);
        rchk(12'h000, 32'h18);
        apb(1, 12'h000, 32'h09);
        enc.step(1, 24);
        enc.drive(3'h5, 24);
        rchk(12'h008, 32'h1);
        enc.drive(3'h1, 24);
        rchk(12'h008, 32'h0);
        enc.step(1, 24);
        apb(1, 12'h000, 32'h39);
        enc.drive(3'h7, 24);
        enc.drive(3'h3, 24);
        rchk(12'h008, 32'h1);
        i_index_gate <= 1;
        enc.drive(3'h7, 24);
        enc.drive(3'h3, 24);
        rchk(12'h008, 32'h0);
        finish_test();
    end
endmodule // qec_counter_tb_top
